/* File: spm_map.vh */
// Register map, field positions, reset values and rate counts for the serial port block.
// Assumes a 100 MHz hclk and an AHB-Lite slave port decoding haddr[11:2] as a word index.
`ifndef SPM_MAP_VH
`define SPM_MAP_VH

// Word indices; byte address is four times the index
`define SPM_IDX_SERIAL_CONTROL 10'h098
`define SPM_IDX_SERIAL_CHAR_BUFFER 10'h099
`define SPM_IDX_POWER_AND_RATE_CONTROL 10'h087
`define SPM_IDX_IE 10'h0a8
`define SPM_IDX_IP 10'h0b8
`define SPM_IDX_RATE 10'h0c0
`define SPM_IDX_IRQ_ST 10'h0c1
`define SPM_IDX_IRQ_MASK 10'h0c2
`define SPM_IDX_SERIAL_CONTROL_BIT 10'h0c3

// Serial control fields
`define SPM_SC_MODE_HI 7
`define SPM_SC_MODE_LO 6
`define SPM_SC_FILTER 5
`define SPM_SC_RX_EN 4
`define SPM_SC_TX_NB 3
`define SPM_SC_RX_NB 2
`define SPM_SC_TX_DONE 1
`define SPM_SC_RX_DONE 0

// Mode codes
`define SPM_MODE_SHIFT 2'h0
`define SPM_MODE_UART8 2'h1
`define SPM_MODE_UART9F 2'h2
`define SPM_MODE_UART9V 2'h3

// Other fields
`define SPM_IE_GLOBAL 7
`define SPM_IE_SERIAL 4
`define SPM_IP_SERIAL 4
`define SPM_POWER_AND_RATE_CONTROL_DOUBLER 7
`define SPM_POWER_AND_RATE_CONTROL_WMASK 8'h8f

// Status bits: tx done, rx done, rx overrun
`define SPM_ST_TX 0
`define SPM_ST_RX 1
`define SPM_ST_OVR 2

// Reset values
`define SPM_RST_SERIAL_CONTROL 8'h00
`define SPM_RST_POWER_AND_RATE_CONTROL 8'h00
`define SPM_RST_IE 8'h00
`define SPM_RST_IP 8'h00
`define SPM_RST_RATE 16'h0364

// Fixed division for shift mode and fixed-rate UART
`define SPM_DIV_FIXED 16'h000c

`endif

/* File: spm_bitclk.v */
// Bit-period counter giving one-cycle tick and mid-bit pulses.
// Assumes div is at least 2 and stays stable during a character.
`timescale 1ns/1ps
module spm_bitclk (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Control
	input wire restart,
	input wire [15:0] div,
	// Pulses
	output wire tick,
	output wire half
);
	reg [15:0] cnt_reg;
	reg [15:0] cnt_next;

	assign tick = (cnt_reg == div - 16'h0001);
	assign half = (cnt_reg == {1'b0, div[15:1]});

	always @* begin
		cnt_next = cnt_reg + 16'h0001;
		if (restart || tick) begin
			cnt_next = 16'h0000;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= 16'h0000;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule // spm_bitclk

/* File: spm_serial_port.v */
// Serial port core: control registers, shift register mode, three UART modes, interrupts.
// Assumes a single AHB-Lite master and synchronous serial inputs.
`include "spm_map.vh"
`timescale 1ns/1ps
module spm_serial_port (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output wire [31:0] hrdata,
	// Serial pins
	input wire rxd_i,
	output wire rxd_o,
	output wire rxd_oe,
	output wire txd_o,
	// Interrupts
	output wire irq,
	output wire serial_irq_high,
	output wire serial_irq_low
);
	// Bit period for the current mode
	function [15:0] spm_div;
		input [1:0] mode;
		input doubler;
		input [15:0] rate;
		begin
			case (mode)
				`SPM_MODE_SHIFT: spm_div = `SPM_DIV_FIXED;
				`SPM_MODE_UART9F: spm_div = `SPM_DIV_FIXED;
				default: spm_div = doubler ? {1'b0, rate[15:1]} : rate;
			endcase
			if (spm_div < 16'h0002) begin
				spm_div = 16'h0002;
			end
		end
	endfunction

	// Bus state
	reg a_valid_reg;
	reg a_write_reg;
	reg [9:0] a_idx_reg;
	reg [31:0] hrdata_reg;
	// Registers
	reg [7:0] serial_control_reg;
	reg [7:0] serial_control_next;
	reg [7:0] serial_char_buffer_reg;
	reg [7:0] interrupt_enable_mask_reg;
	reg [7:0] interrupt_priority_select_reg;
	reg [7:0] power_and_rate_control_reg;
	reg [15:0] rate_reg;
	reg [2:0] irq_st_reg;
	reg [2:0] irq_st_next;
	reg [2:0] irq_mask_reg;
	// Transmit engine
	reg tx_busy_reg;
	reg [10:0] tx_sh_reg;
	reg [3:0] tx_cnt_reg;
	reg tx_clk_reg;
	reg tx_mode0_reg;
	// Receive engine
	localparam RX_IDLE = 3'b001;
	localparam RX_UART = 3'b010;
	localparam RX_SHIFT = 3'b100;
	reg [2:0] rx_state_reg;
	reg [10:0] rx_sh_reg;
	reg [3:0] rx_cnt_reg;
	reg rx_clk_reg;
	reg rx_nine_reg;

	wire [9:0] idx = haddr[11:2];
	wire take = hsel && hready && htrans[1];
	wire wr = a_valid_reg && a_write_reg;
	wire [1:0] mode = {serial_control_reg[`SPM_SC_MODE_HI], serial_control_reg[`SPM_SC_MODE_LO]};
	wire nine = mode[1];
	wire shift_mode = (mode == `SPM_MODE_SHIFT);
	wire [15:0] div = spm_div(mode, power_and_rate_control_reg[`SPM_POWER_AND_RATE_CONTROL_DOUBLER], rate_reg);
	wire rx_en = serial_control_reg[`SPM_SC_RX_EN];
	wire ri = serial_control_reg[`SPM_SC_RX_DONE];
	wire ti = serial_control_reg[`SPM_SC_TX_DONE];
	wire filt = serial_control_reg[`SPM_SC_FILTER];

	wire wr_serial_control = wr && (a_idx_reg == `SPM_IDX_SERIAL_CONTROL);
	wire wr_serial_char_buffer = wr && (a_idx_reg == `SPM_IDX_SERIAL_CHAR_BUFFER);
	wire wr_bit = wr && (a_idx_reg == `SPM_IDX_SERIAL_CONTROL_BIT);
	wire wr_st = wr && (a_idx_reg == `SPM_IDX_IRQ_ST);
	wire tx_start = wr_serial_char_buffer && !tx_busy_reg;

	wire tx_tick;
	wire tx_half;
	wire rx_tick;
	wire rx_half;
	wire rx_go_uart = (rx_state_reg == RX_IDLE) && rx_en && !shift_mode && !rxd_i;
	wire rx_go_shift = (rx_state_reg == RX_IDLE) && rx_en && shift_mode && !ri && !tx_busy_reg;
	wire rx_restart = rx_go_uart || rx_go_shift;
	wire tx_fin = tx_busy_reg && tx_tick && (tx_cnt_reg == 4'h1);
	wire rx_last = rx_half && (rx_cnt_reg == 4'h1);
	// The last sample is not in rx_sh_reg yet on the edge that completes the frame
	wire [10:0] rx_sh_in = {rxd_i, rx_sh_reg[10:1]};
	wire [7:0] rx_data = (rx_state_reg == RX_SHIFT) ? rx_sh_in[10:3] :
		(rx_nine_reg ? rx_sh_in[8:1] : rx_sh_in[9:2]);
	// Shift mode has no ninth bit, so the stored one is kept
	wire rx_nb = (rx_state_reg == RX_SHIFT) ? serial_control_reg[`SPM_SC_RX_NB] :
		(rx_nine_reg ? rx_sh_in[9] : rx_sh_in[10]);
	wire rx_stop = rx_sh_in[10];
	// Frame accepted unless filtered or the last one is still unread
	wire rx_ok = (rx_state_reg == RX_SHIFT) ||
		(!ri && (rx_nine_reg ? (!filt || rx_nb) : (!filt || rx_stop)));
	wire rx_done = rx_last && (rx_state_reg != RX_IDLE);
	wire rx_fin = rx_done && rx_ok;
	wire rx_ovr = rx_done && (rx_state_reg == RX_UART) && ri;

	spm_bitclk u_tx_clk (
		.hclk(hclk),
		.hresetn(hresetn),
		.restart(tx_start),
		.div(div),
		.tick(tx_tick),
		.half(tx_half)
	);

	spm_bitclk u_rx_clk (
		.hclk(hclk),
		.hresetn(hresetn),
		.restart(rx_restart),
		.div(div),
		.tick(rx_tick),
		.half(rx_half)
	);

	// Zero-wait slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	// Read mux used at the address phase
	function [31:0] spm_rd;
		input [9:0] i;
		begin
			case (i)
				`SPM_IDX_SERIAL_CONTROL: spm_rd = {24'h000000, serial_control_reg};
				`SPM_IDX_SERIAL_CHAR_BUFFER: spm_rd = {24'h000000, serial_char_buffer_reg};
				`SPM_IDX_POWER_AND_RATE_CONTROL: spm_rd = {24'h000000, power_and_rate_control_reg};
				`SPM_IDX_IE: spm_rd = {24'h000000, interrupt_enable_mask_reg};
				`SPM_IDX_IP: spm_rd = {24'h000000, interrupt_priority_select_reg};
				`SPM_IDX_RATE: spm_rd = {16'h0000, rate_reg};
				`SPM_IDX_IRQ_ST: spm_rd = {26'h0000000, (rx_state_reg != RX_IDLE), tx_busy_reg,
					1'b0, irq_st_reg};
				`SPM_IDX_IRQ_MASK: spm_rd = {29'h00000000, irq_mask_reg};
				default: spm_rd = 32'h00000000;
			endcase
		end
	endfunction

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_valid_reg <= 1'b0;
			a_write_reg <= 1'b0;
			a_idx_reg <= 10'h000;
			hrdata_reg <= 32'h00000000;
		end else if (hready) begin
			a_valid_reg <= take;
			a_write_reg <= hwrite;
			a_idx_reg <= idx;
			if (take && !hwrite) begin
				hrdata_reg <= spm_rd(idx);
			end
		end
	end

	// Serial control update; hardware set wins over software clear
	always @* begin
		serial_control_next = serial_control_reg;
		if (wr_serial_control) begin
			serial_control_next = hwdata[7:0];
		end else if (wr_bit) begin
			serial_control_next[hwdata[2:0]] = hwdata[4];
		end
		if (tx_fin) begin
			serial_control_next[`SPM_SC_TX_DONE] = 1'b1;
		end
		if (rx_fin) begin
			serial_control_next[`SPM_SC_RX_DONE] = 1'b1;
			serial_control_next[`SPM_SC_RX_NB] = rx_nb;
		end
	end

	// Event status: write one to clear, set wins
	always @* begin
		irq_st_next = irq_st_reg;
		if (wr_st) begin
			irq_st_next = irq_st_reg & ~hwdata[2:0];
		end
		if (tx_fin) begin
			irq_st_next[`SPM_ST_TX] = 1'b1;
		end
		if (rx_fin) begin
			irq_st_next[`SPM_ST_RX] = 1'b1;
		end
		if (rx_ovr) begin
			irq_st_next[`SPM_ST_OVR] = 1'b1;
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_control_reg <= `SPM_RST_SERIAL_CONTROL;
			serial_char_buffer_reg <= 8'h00;
			interrupt_enable_mask_reg <= `SPM_RST_IE;
			interrupt_priority_select_reg <= `SPM_RST_IP;
			power_and_rate_control_reg <= `SPM_RST_POWER_AND_RATE_CONTROL;
			rate_reg <= `SPM_RST_RATE;
			irq_st_reg <= 3'h0;
			irq_mask_reg <= 3'h0;
		end else begin
			serial_control_reg <= serial_control_next;
			irq_st_reg <= irq_st_next;
			// received character lands in the buffer
			if (rx_fin) begin
				serial_char_buffer_reg <= rx_data;
			end
			if (wr && (a_idx_reg == `SPM_IDX_IE)) begin
				interrupt_enable_mask_reg <= hwdata[7:0];
			end
			if (wr && (a_idx_reg == `SPM_IDX_IP)) begin
				interrupt_priority_select_reg <= hwdata[7:0];
			end
			// Reserved bits keep reading zero
			if (wr && (a_idx_reg == `SPM_IDX_POWER_AND_RATE_CONTROL)) begin
				power_and_rate_control_reg <= hwdata[7:0] & `SPM_POWER_AND_RATE_CONTROL_WMASK;
			end
			if (wr && (a_idx_reg == `SPM_IDX_RATE)) begin
				rate_reg <= hwdata[15:0];
			end
			if (wr && (a_idx_reg == `SPM_IDX_IRQ_MASK)) begin
				irq_mask_reg <= hwdata[2:0];
			end
		end
	end

	// Transmit: writing the buffer starts a character; ignored while busy
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_busy_reg <= 1'b0;
			tx_sh_reg <= 11'h7ff;
			tx_cnt_reg <= 4'h0;
			tx_clk_reg <= 1'b1;
			tx_mode0_reg <= 1'b0;
		end else if (tx_start) begin
			tx_busy_reg <= 1'b1;
			tx_mode0_reg <= shift_mode;
			tx_clk_reg <= 1'b0;
			if (shift_mode) begin
				tx_sh_reg <= {3'h7, hwdata[7:0]};
				tx_cnt_reg <= 4'h8;
			end else if (nine) begin
				tx_sh_reg <= {1'b1, serial_control_reg[`SPM_SC_TX_NB], hwdata[7:0], 1'b0};
				tx_cnt_reg <= 4'hb;
			end else begin
				tx_sh_reg <= {2'h3, hwdata[7:0], 1'b0};
				tx_cnt_reg <= 4'ha;
			end
		end else if (tx_busy_reg) begin
			if (tx_half) begin
				tx_clk_reg <= 1'b1;
			end
			if (tx_tick) begin
				tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
				tx_cnt_reg <= tx_cnt_reg - 4'h1;
				if (tx_cnt_reg == 4'h1) begin
					tx_busy_reg <= 1'b0;
					tx_clk_reg <= 1'b1;
				end else begin
					tx_clk_reg <= 1'b0;
				end
			end
		end
	end

	// Receive: samples at mid-bit, start bit rechecked to reject glitches
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_state_reg <= RX_IDLE;
			rx_sh_reg <= 11'h000;
			rx_cnt_reg <= 4'h0;
			rx_clk_reg <= 1'b1;
			rx_nine_reg <= 1'b0;
		end else begin
			case (rx_state_reg)
				RX_IDLE: begin
					if (rx_go_uart) begin
						rx_state_reg <= RX_UART;
						rx_nine_reg <= nine;
						rx_cnt_reg <= nine ? 4'hb : 4'ha;
					end else if (rx_go_shift) begin
						rx_state_reg <= RX_SHIFT;
						rx_cnt_reg <= 4'h8;
						rx_clk_reg <= 1'b0;
					end
				end
				RX_UART: begin
					if (rx_half) begin
						rx_sh_reg <= {rxd_i, rx_sh_reg[10:1]};
						rx_cnt_reg <= rx_cnt_reg - 4'h1;
						if (rx_last) begin
							rx_state_reg <= RX_IDLE;
						end else if (rxd_i && (rx_cnt_reg == (rx_nine_reg ? 4'hb : 4'ha))) begin
							rx_state_reg <= RX_IDLE;
						end
					end
				end
				RX_SHIFT: begin
					if (rx_half) begin
						rx_clk_reg <= 1'b1;
						rx_sh_reg <= {rxd_i, rx_sh_reg[10:1]};
						rx_cnt_reg <= rx_cnt_reg - 4'h1;
						if (rx_last) begin
							rx_state_reg <= RX_IDLE;
						end
					end else if (rx_tick) begin
						rx_clk_reg <= 1'b0;
					end
				end
				default: begin
					rx_state_reg <= RX_IDLE;
				end
			endcase
		end
	end

	// Shift mode drives data on rxd and the shift clock on txd
	assign rxd_oe = tx_busy_reg && tx_mode0_reg;
	assign rxd_o = tx_sh_reg[0];
	assign txd_o = shift_mode ? (tx_clk_reg & rx_clk_reg) : tx_sh_reg[0];

	assign irq = |(irq_st_reg & irq_mask_reg);
	wire serial_req = (ti || ri) && interrupt_enable_mask_reg[`SPM_IE_SERIAL] &&
		interrupt_enable_mask_reg[`SPM_IE_GLOBAL];
	assign serial_irq_high = serial_req && interrupt_priority_select_reg[`SPM_IP_SERIAL];
	assign serial_irq_low = serial_req && !interrupt_priority_select_reg[`SPM_IP_SERIAL];
endmodule // spm_serial_port

/* File: spm_serial_port_checker.sv */
// Port-level checks for the serial port block.
// Assumes hready is fed from hreadyout and one clock domain.
`timescale 1ns/1ps
module spm_serial_port_checker (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Bus
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	// Serial and interrupts
	input wire rxd_oe,
	input wire txd_o,
	input wire irq,
	input wire serial_irq_high,
	input wire serial_irq_low
);
	logic wr_q;
	logic rd_q;
	logic [7:0] oe_cnt;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			oe_cnt <= 8'h00;
		end else begin
			wr_q <= hsel && hready && htrans[1] && hwrite;
			rd_q <= hsel && hready && htrans[1] && !hwrite;
			oe_cnt <= rxd_oe ? oe_cnt + 8'h01 : 8'h00;
		end
	end
	a_prio_excl: assert property (!(serial_irq_high && serial_irq_low))
		else $error("both priority outputs high");
	a_irq_sticky: assert property ($fell(irq) |-> $past(wr_q))
		else $error("irq dropped without a write");
	a_sirq_sticky: assert property ($fell(serial_irq_high | serial_irq_low) |-> $past(wr_q))
		else $error("serial request dropped without a write");
	a_resp_okay: assert property (hreadyout && !hresp)
		else $error("wait state or error response");
	a_rdata_hold: assert property ($changed(hrdata) |-> rd_q)
		else $error("read data changed without a read");
	a_oe_bounded: assert property (oe_cnt <= 8'h64)
		else $error("shift output enable held too long");
	a_shift_clock: assert property (rxd_oe && $fell(txd_o) |-> !txd_o [*7] ##1 txd_o)
		else $error("shift clock low phase not seven cycles");
	a_oe_start: assert property ($rose(rxd_oe) |-> $past(wr_q) || $past(wr_q, 2))
		else $error("shift transfer began without a write");
	cover property ($rose(irq));
	cover property ($rose(rxd_oe));
	cover property ($rose(serial_irq_high));
endmodule // spm_serial_port_checker

bind spm_serial_port spm_serial_port_checker spm_serial_port_checker_inst (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd_oe(rxd_oe), .txd_o(txd_o),
	.irq(irq), .serial_irq_high(serial_irq_high), .serial_irq_low(serial_irq_low));

/* File: spm_term.sv */
// Remote serial terminal: frames characters onto rxd, samples txd.
// Assumes bit periods are given in hclk cycles; line idles high.
`timescale 1ns/1ps
module spm_term (
	// Clock
	input wire hclk,
	// Serial lines
	input wire txd_o,
	output logic rxd_line
);
	initial rxd_line = 1'b1;
	task send(input [8:0] c, input int n, input int d);
		int i;
		for (i = 0; i < n + 2; i++) begin
			rxd_line <= (i == 0) ? 1'b0 : (i > n) ? 1'b1 : c[(i + 8) % 9];
			repeat (d) @(posedge hclk);
		end
	endtask
	task grab(output [9:0] v, input int n, input int d);
		int i;
		v = 10'h000;
		i = 0;
		while (txd_o !== 1'b0 && i < 4000) begin
			@(posedge hclk);
			i++;
		end
		repeat (d / 2) @(posedge hclk);
		for (i = 0; i <= n; i++) begin
			repeat (d) @(posedge hclk);
			v[i] = txd_o;
		end
	endtask
endmodule // spm_term

/* File: spm_serial_port_tb_top.sv */
// Testbench for the serial port block: AHB-Lite tasks, terminal model.
// Assumes hready is fed from hreadyout.
`timescale 1ns/1ps
`include "spm_map.vh"
module spm_serial_port_tb_top;
	localparam [11:0] A_SC = {`SPM_IDX_SERIAL_CONTROL, 2'b00};
	localparam [11:0] A_SB = {`SPM_IDX_SERIAL_CHAR_BUFFER, 2'b00};
	localparam [11:0] A_PC = {`SPM_IDX_POWER_AND_RATE_CONTROL, 2'b00};
	localparam [11:0] A_IE = {`SPM_IDX_IE, 2'b00};
	localparam [11:0] A_IP = {`SPM_IDX_IP, 2'b00};
	localparam [11:0] A_RT = {`SPM_IDX_RATE, 2'b00};
	localparam [11:0] A_ST = {`SPM_IDX_IRQ_ST, 2'b00};
	localparam [11:0] A_MK = {`SPM_IDX_IRQ_MASK, 2'b00};
	localparam [11:0] A_BT = {`SPM_IDX_SERIAL_CONTROL_BIT, 2'b00};
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] q;
	logic [9:0] v;
	wire hready, hresp, rxd_o, rxd_oe, txd_o, irq, s_hi, s_lo, t_rxd;
	wire [31:0] hrdata;
	int err_count = 0;
	int samples_checked = 0;
	int k;
	logic [7:0] t_sc [4] = '{8'h40, 8'hc8, 8'h80, 8'h40};
	logic [7:0] t_pc [4] = '{8'h00, 8'h00, 8'h00, 8'h80};
	int t_d [4] = '{8, 8, 12, 4};
	int t_n [4] = '{8, 9, 9, 8};
	logic [9:0] t_x [4] = '{10'h1a5, 10'h33c, 10'h23c, 10'h15a};
	always #5 hclk = ~hclk;
	spm_serial_port spm_serial_port_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.rxd_i(rxd_oe ? rxd_o : t_rxd), .rxd_o(rxd_o), .rxd_oe(rxd_oe), .txd_o(txd_o),
		.irq(irq), .serial_irq_high(s_hi), .serial_irq_low(s_lo));
	spm_term spm_term_inst (.hclk(hclk), .txd_o(txd_o), .rxd_line(t_rxd));
	task tally_and_finish;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task wait_rdy;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hready !== 1'b1 && i < 50);
		if (hready !== 1'b1) begin
			err_count++;
			tally_and_finish;
		end
	endtask
	task bus(input w, input [11:0] a, input [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		q = hrdata;
	endtask
	task wr(input [11:0] a, input [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rd(input [11:0] a, input [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task poll(input [11:0] a, input [31:0] m);
		int i;
		i = 0;
		do begin
			bus(1'b0, a, 32'h0);
			i++;
		end while ((q & m) == 32'h0 && i < 3000);
		chk(q & m, m);
	endtask
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(A_SC, 0);
		rd(A_SB, 0);
		rd(A_PC, 0);
		rd(A_IE, 0);
		rd(A_IP, 0);
		rd(A_RT, 32'h364);
		rd(A_ST, 0);
		rd(A_MK, 0);
		wr(A_MK, 3);
		wr(A_RT, 8);
		for (k = 0; k < 4; k++) begin
			wr(A_SC, t_sc[k]);
			wr(A_PC, t_pc[k]);
			wr(A_SB, t_x[k][7:0]);
			spm_term_inst.grab(v, t_n[k], t_d[k]);
			chk(v, t_x[k]);
			poll(A_ST, 1);
			rd(A_SC, t_sc[k] | 8'h02);
			wr(A_ST, 1);
			wr(A_SC, 0);
		end
		wr(A_PC, 0);
		wr(A_SC, 8'hd0);
		spm_term_inst.send(9'h15a, 9, 8);
		poll(A_ST, 2);
		rd(A_SB, 8'h5a);
		rd(A_SC, 8'hd5);
		// A second frame while the first is unread is dropped as overrun
		spm_term_inst.send(9'h0a5, 9, 8);
		poll(A_ST, 4);
		rd(A_SB, 8'h5a);
		wr(A_IE, 8'h90);
		for (k = 1; k >= 0; k--) begin
			wr(A_IP, k << 4);
			@(posedge hclk);
			chk(s_hi, k);
			chk(s_lo, 1 - k);
		end
		wr(A_SC, 8'h40);
		wr(A_ST, 7);
		spm_term_inst.send(9'h0c3, 8, 8);
		rd(A_ST, 0);
		// Shift receive starts at once, so the line's first low bit lands in bit 0
		wr(A_SC, 8'h10);
		spm_term_inst.send(9'h0e7, 8, 12);
		poll(A_ST, 2);
		rd(A_SB, 8'hce);
		rd(A_SC, 8'h11);
		wr(A_ST, 2);
		wr(A_SC, 0);
		wr(A_MK, 0);
		wr(A_SB, 8'h81);
		repeat (6) @(posedge hclk);
		chk(rxd_oe, 1);
		for (k = 0; k < 8; k++) begin
			v[k] = rxd_o;
			repeat (12) @(posedge hclk);
		end
		chk(v[7:0], 8'h81);
		poll(A_ST, 1);
		chk(irq, 0);
		wr(A_MK, 1);
		@(posedge hclk);
		chk(irq, 1);
		wr(A_ST, 1);
		@(posedge hclk);
		chk(irq, 0);
		wr(A_SC, 0);
		wr(A_BT, 8'h13);
		rd(A_SC, 8'h08);
		wr(12'h3f0, 32'h5a);
		rd(12'h3f0, 0);
		tally_and_finish;
	end
endmodule // spm_serial_port_tb_top
